// *** logic/sipo8_pkg.sv ***
// Purpose: shared constants for the serial-in parallel-out latch
// Assumes: pins sampled by clk_sys
// Notes: none
package sipo8_pkg;
  localparam int SIPO8_WIDTH = 8;
  localparam int SIPO8_FIFO_DEPTH = 8;
  localparam int SIPO8_SYNC_STAGES = 2;
  localparam int SIPO8_PIN_COUNT = 5;
  localparam logic [4:0] SIPO8_PIN_IDLE = 5'h14;
  localparam logic [7:0] SIPO8_SHIFT_RST = 8'h00;
  localparam logic [7:0] SIPO8_STORE_RST = 8'h00;
  localparam int SIPO8_LINK_PERIOD_NS = 125;
  localparam int SIPO8_CLK_PERIOD_NS = 8;
  localparam int SIPO8_LINK_CYCLES = (SIPO8_LINK_PERIOD_NS + SIPO8_CLK_PERIOD_NS - 1)
                                     / SIPO8_CLK_PERIOD_NS;
endpackage

// *** logic/sipo8_fifo.sv ***
// Purpose: small valid/ready FIFO for captured storage words
// Assumes: one clock, asynchronous active-high reset
// Notes: depth must be a power of two
`timescale 1ns/1ps
module sipo8_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  wire push;
  wire pop;
  wire empty;
  wire full;

  // Status and handshake decode
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem[rd_ptr_r[AW-1:0]]; // Head word straight from the array

  // Storage array write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule

// *** logic/sipo8_top.sv ***
// Purpose: pin-level shift/storage latch, pins sampled on clk_sys
// Purpose: every pin passes two flops, so each pin edge acts three clk_sys edges late
// Assumes: pin clocks are slow against clk_sys (125 ns against 8 ns)
// Assumes: each pin level holds at least one clk_sys cycle, shorter pulses can be missed
// Assumes: serial data settles with the shift clock's fall, well before its rise
// Notes: storage words also pass an 8-deep FIFO toward a word stream port
// Notes: a storage edge that finds the FIFO full sets the sticky overflow; its word, pushed a cycle later, drops only if the FIFO is still full
// Notes: the clear is synchronised too, so it takes effect a few clk_sys cycles late
// Notes: parallel value and enable leave one flop bank, so they switch in the same cycle
// Notes: word_data shows the FIFO head while word_valid is high
`timescale 1ns/1ps
module sipo8_top
  import sipo8_pkg::*;
#(
  parameter int WIDTH = SIPO8_WIDTH,
  parameter int FIFO_DEPTH = SIPO8_FIFO_DEPTH
) (
  // System
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Controller pins
  input wire logic serial_data_in,
  input wire logic shift_clock,
  input wire logic shift_clear_n,
  input wire logic store_clock,
  input wire logic out_enable_n,
  // Parallel outputs, two signals each
  output logic [WIDTH-1:0] par_out,
  output logic [WIDTH-1:0] par_oe_n,
  // Cascade output
  output logic serial_cascade_out,
  // Stored word stream
  output logic word_valid,
  input wire logic word_ready,
  output logic [WIDTH-1:0] word_data,
  output logic word_overflow
);
  // Synchronised pin levels and clock history
  wire [SIPO8_PIN_COUNT-1:0] pins;
  wire [SIPO8_PIN_COUNT-1:0] pins_s;
  logic shclk_prev_r;
  logic stclk_prev_r;

  // Shift and storage state
  logic [WIDTH-1:0] shift_r;
  logic [WIDTH-1:0] shift_nxt;
  logic [WIDTH-1:0] store_r;
  logic [WIDTH-1:0] store_nxt;

  // Registered parallel drivers
  logic [WIDTH-1:0] par_out_r;
  logic [WIDTH-1:0] par_oe_n_r;
  logic [WIDTH-1:0] par_out_nxt;

  // Word stream status
  logic overflow_r;
  logic fifo_ready;

  // Named pin levels after synchronisation
  wire din_s;
  wire shclk_s;
  wire clr_n_s;
  wire stclk_s;
  wire oe_n_s;

  // Decoded events
  wire shift_rise;
  wire store_rise;
  wire clear_act;

  // Pin order inside the synchroniser bank
  assign pins = {out_enable_n, store_clock, shift_clear_n, shift_clock, serial_data_in};
  assign din_s = pins_s[0];
  assign shclk_s = pins_s[1];
  assign clr_n_s = pins_s[2];
  assign stclk_s = pins_s[3];
  assign oe_n_s = pins_s[4];

  // One two-flop synchroniser per pin; only the second flop reads the first
  generate
    for (genvar p = 0; p < SIPO8_PIN_COUNT; p++) begin : g_sync
      logic meta_r;
      logic stable_r;
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          meta_r <= SIPO8_PIN_IDLE[p]; // Clear and enable idle high
          stable_r <= SIPO8_PIN_IDLE[p];
        end else begin
          meta_r <= pins[p];
          stable_r <= meta_r;
        end
      end
      assign pins_s[p] = stable_r;
    end
  endgenerate

  // Shift clock history, idle level low so reset makes no false edge
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shclk_prev_r <= 1'b0;
    end else begin
      shclk_prev_r <= shclk_s;
    end
  end

  // Storage clock history, same idle level
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stclk_prev_r <= 1'b0;
    end else begin
      stclk_prev_r <= stclk_s;
    end
  end

  // Only a low-to-high step of a synchronised clock acts
  assign shift_rise = shclk_s && !shclk_prev_r;
  assign store_rise = stclk_s && !stclk_prev_r;
  // Clear level after synchronisation; overrides any shift edge
  assign clear_act = !clr_n_s;

  // Next shift value: serial in at stage 0, others move up
  assign shift_nxt = {shift_r[WIDTH-2:0], din_s};
  // Storage takes the pre-shift stages; a held clear gives zero
  assign store_nxt = clr_n_s ? shift_r : '0;

  // Shift stages; reset value is a simulation convenience only
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shift_r <= WIDTH'(SIPO8_SHIFT_RST);
    end else if (clear_act) begin
      shift_r <= '0;
    end else if (shift_rise) begin
      shift_r <= shift_nxt;
    end
  end

  // Storage register takes the old shift value, or zero under a held clear; clear alone does not touch it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      store_r <= WIDTH'(SIPO8_STORE_RST);
    end else if (store_rise) begin
      store_r <= store_nxt;
    end
  end

  // Per-bit driver values, zero while the outputs float
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_drv
      assign par_out_nxt[i] = oe_n_s ? 1'b0 : store_r[i];
    end
  endgenerate

  // Value and enable share one flop bank, so they never switch apart
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      par_out_r <= '0;
      par_oe_n_r <= '1;
    end else begin
      par_out_r <= par_out_nxt;
      par_oe_n_r <= {WIDTH{oe_n_s}};
    end
  end
  assign par_out = par_out_r;
  assign par_oe_n = par_oe_n_r;

  // Cascade output always driven from last stage
  assign serial_cascade_out = shift_r[WIDTH-1];

  // Overflow flag when a stored word finds the FIFO full
  // The dropped word is lost; the flag stays until system reset
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_r <= 1'b0;
    end else if (store_rise && !fifo_ready) begin
      overflow_r <= 1'b1;
    end
  end
  assign word_overflow = overflow_r;

  // Word of each storage edge queued one cycle later
  logic push_r;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      push_r <= 1'b0;
    end else begin
      push_r <= store_rise;
    end
  end

  // Word FIFO toward the stream port
  sipo8_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(push_r),
    .in_ready(fifo_ready),
    .in_data(store_r),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_data)
  );
endmodule

// *** verif/sipo8_props.sv ***
// Purpose: pin checks on sipo8_top. Assumes: slow pins. Notes: bound below.
`timescale 1ns/1ps
module sipo8_props #(parameter int WIDTH = 8) (
  // Watched ports
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic shift_clock,
  input wire logic shift_clear_n,
  input wire logic store_clock,
  input wire logic out_enable_n,
  input wire logic [WIDTH-1:0] par_out,
  input wire logic [WIDTH-1:0] par_oe_n,
  input wire logic serial_cascade_out,
  input wire logic word_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Enable level held past the synchronizer
  sequence s_off; out_enable_n[*5]; endsequence
  sequence s_on; !out_enable_n[*5]; endsequence
  a_oe_off: assert property (s_off |-> &par_oe_n) else $error("oe off");
  a_oe_on: assert property (s_on |-> par_oe_n == '0) else $error("oe on");
  a_oe_whole: assert property (&par_oe_n || par_oe_n == '0) else $error("oe split");
  a_off_zero: assert property (&par_oe_n |-> par_out == '0) else $error("float");
  a_clr_zero: assert property (!shift_clear_n[*4] |-> !serial_cascade_out)
    else $error("clear");
  a_shift_idle: assert property (($stable(shift_clock) && shift_clear_n)[*6]
    |-> $stable(serial_cascade_out)) else $error("shift");
  a_store_idle: assert property (($stable(store_clock) && !out_enable_n)[*6]
    |-> $stable(par_out)) else $error("store");
  a_store_word: assert property ($rose(store_clock) |-> ##[2:10] word_valid)
    else $error("word");
endmodule
bind sipo8_top sipo8_props #(.WIDTH(WIDTH)) u_props (.clk_sys, .sys_rst, .shift_clock,
  .shift_clear_n, .store_clock, .out_enable_n, .par_out, .par_oe_n, .serial_cascade_out, .word_valid);

// *** verif/sipo8_host.sv ***
// Purpose: controller on the pins. Assumes: falling-edge pacing. Notes: link clock idles low.
`timescale 1ns/1ps
module sipo8_host (
  // Pacing clock and driven pins
  input wire logic clk_sys,
  output logic serial_data_in,
  output logic shift_clock,
  output logic shift_clear_n,
  output logic store_clock
);
  // Idle: clocks low, clear released
  initial {serial_data_in, shift_clock, shift_clear_n, store_clock} = 4'h2;
  // MSB first; st joins a storage edge to the first shift edge
  task automatic send(input logic [7:0] b, input logic st);
    for (int i = 7; i >= 0; i--) begin
      serial_data_in = b[i];
      repeat (8) @(negedge clk_sys);
      shift_clock = 1'b1;
      store_clock = st && i == 7;
      repeat (8) @(negedge clk_sys);
      shift_clock = 1'b0;
      store_clock = 1'b0;
    end
    serial_data_in = ~b[0]; // Released line shows no stale bit
    repeat (8) @(negedge clk_sys);
  endtask
  // Storage and clear strobes, half a link period each
  task automatic pulse(input logic st, input logic clr_n);
    store_clock = st;
    shift_clear_n = clr_n;
    repeat (8) @(negedge clk_sys);
    store_clock = 1'b0;
    shift_clear_n = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule

// *** verif/testbench.sv ***
// Purpose: self-checking bench. Assumes: host model paces pins. Notes: FIFO fills over the run.
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0, sys_rst = 1'b1, word_ready = 1'b0, out_enable_n = 1'b1;
  logic serial_data_in, shift_clock, shift_clear_n, store_clock, serial_cascade_out;
  logic word_valid, word_overflow;
  logic [7:0] par_out, par_oe_n, word_data;
  int miscompares = 0, n_tests = 0;
  always #4 clk_sys = ~clk_sys;
  sipo8_host u_host (
    .clk_sys(clk_sys),
    .serial_data_in(serial_data_in),
    .shift_clock(shift_clock),
    .shift_clear_n(shift_clear_n),
    .store_clock(store_clock)
  );
  sipo8_top dut (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .serial_data_in(serial_data_in),
    .shift_clock(shift_clock),
    .shift_clear_n(shift_clear_n),
    .store_clock(store_clock),
    .out_enable_n(out_enable_n),
    .par_out(par_out),
    .par_oe_n(par_oe_n),
    .serial_cascade_out(serial_cascade_out),
    .word_valid(word_valid),
    .word_ready(word_ready),
    .word_data(word_data),
    .word_overflow(word_overflow)
  );
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    miscompares += int'(g !== e);
    if (g !== e) $display("mismatch %s exp %h got %h", s, e, g);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic step(input logic st, input logic clr_n, input logic [7:0] e);
    u_host.pulse(st, clr_n);
    chk("par_out", e, par_out);
  endtask
  task automatic t_load();
    step(1'b0, 1'b0, 8'h00);
    step(1'b1, 1'b1, 8'h00);
    chk("oe_n", 8'hff, par_oe_n);
    out_enable_n = 1'b0;
    u_host.send(8'ha5, 1'b0);
    chk("oe_n", 8'h00, par_oe_n);
    chk("cascade", 8'h01, 8'(serial_cascade_out));
    step(1'b1, 1'b1, 8'ha5);
    $display("t_load done");
  endtask
  task automatic t_joint();
    out_enable_n = 1'b1;
    u_host.send(8'h3c, 1'b1);
    out_enable_n = 1'b0;
    step(1'b0, 1'b1, 8'ha5);
    chk("cascade", 8'h00, 8'(serial_cascade_out));
    step(1'b1, 1'b1, 8'h3c);
    step(1'b0, 1'b0, 8'h3c);
    step(1'b1, 1'b1, 8'h00);
    $display("t_joint done");
  endtask
  task automatic t_fifo();
    logic [7:0] exp_w [8] = '{8'h00, 8'ha5, 8'ha5, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (4) step(1'b1, 1'b1, 8'h00);
    chk("overflow", 8'h01, 8'(word_overflow));
    chk("head", 8'h00, word_data);
    word_ready = 1'b1;
    foreach (exp_w[k]) begin
      chk("word", exp_w[k], word_data);
      @(negedge clk_sys);
    end
    step(1'b0, 1'b1, 8'h00);
    chk("valid", 8'h00, 8'(word_valid));
    $display("t_fifo done");
  endtask
  // Reset for five cycles, then the tests
  initial begin
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_load();
    t_joint();
    t_fifo();
    final_report();
  end
  // Watchdog, far past the few microseconds needed
  initial begin
    #50000;
    miscompares++;
    final_report();
  end
endmodule
